// ==== hdl/imb_consts.svh ====
// constants of the interrupt mask bank: register indices, layouts, resets
// assumes inclusion by bare name from the design files of this block
`ifndef IMB_CONSTS_SVH
`define IMB_CONSTS_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define IMB_IDX_S1 6'h19
`define IMB_IDX_S2 6'h1a
`define IMB_IDX_SUV 6'h1c
`define IMB_IDX_SOC 6'h1d
`define IMB_IDX_SGP 6'h1e
`define IMB_IDX_GRP 6'h20
`define IMB_IDX_M1 6'h21
`define IMB_IDX_M2 6'h22
`define IMB_IDX_UV 6'h24
`define IMB_IDX_OC 6'h25
`define IMB_IDX_GP 6'h26

// ************************************************************
// widths and reset values
// ************************************************************
`define IMB_WORD_W 16
`define IMB_FLAG_W 80
`define IMB_ALIGN_OK 2'b00
`define IMB_GRP_RST 16'h33ff
`define IMB_SRC_RST 16'h0000

// ************************************************************
// implemented bits of each register
// ************************************************************
`define IMB_IMPL_GRP 16'h33ff
`define IMB_IMPL_ONE 16'hfee7
`define IMB_IMPL_TWO 16'h35ff
`define IMB_IMPL_UV 16'h0f3f
`define IMB_IMPL_OC 16'h8000
`define IMB_IMPL_GP 16'h1fff

// ************************************************************
// source fields feeding each group
// ************************************************************
`define IMB_F_CHG 16'hfe07
`define IMB_F_RTC 16'h00e0
`define IMB_F_CS 16'h3000
`define IMB_F_USB 16'h0400
`define IMB_F_AUX 16'h01f0
`define IMB_F_SYS 16'h000f

// ************************************************************
// group bit positions
// ************************************************************
`define IMB_G_OC 13
`define IMB_G_UV 12
`define IMB_G_CS 9
`define IMB_G_EXT 8
`define IMB_G_AUD 7
`define IMB_G_GP 6
`define IMB_G_AUX 5
`define IMB_G_RTC 4
`define IMB_G_SYS 3
`define IMB_G_CHG 2
`define IMB_G_USB 1
`define IMB_G_WAKE 0

`endif

// ==== hdl/imb_pkg.sv ====
// types of the interrupt mask bank
// assumes nothing of its surroundings
package imb_pkg;
   // one register word
   typedef logic [15:0] imb_word_t;
   // register slots reached over the bus
   typedef enum logic [3:0] {
      IMB_NONE, IMB_GRP, IMB_M1, IMB_M2, IMB_MUV, IMB_MOC, IMB_MGP,
      IMB_S1, IMB_S2, IMB_SUV, IMB_SOC, IMB_SGP
   } imb_reg_e;
endpackage : imb_pkg

// ==== hdl/imb_flag_bank.sv ====
// sticky status flags: synchronise, catch rising edges, clear on request
// assumes event inputs come from outside the mclk domain
`timescale 1ns/1ps
`default_nettype none
`include "imb_consts.svh"

module imb_flag_bank #(
   parameter int W = `IMB_FLAG_W,
   parameter logic [W-1:0] IMPL = '1
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [W-1:0] evt_in,
   input wire logic [W-1:0] clr,
   output logic [W-1:0] flags
);

   // ************************************************************
   // elaboration check
   // ************************************************************
   generate
      if (W < 1) begin : g_bad_w
         $error("imb_flag_bank: W must be at least one");
      end
   endgenerate

   logic [W-1:0] sync1_r; // first stage, read by sync2 only
   logic [W-1:0] sync2_r; // synchronised level
   logic [W-1:0] prev_r; // level one cycle ago
   logic [W-1:0] flags_nxt;
   wire [W-1:0] rise_w = sync2_r & ~prev_r & IMPL;
   wire [W-1:0] clr_only_w = clr & ~rise_w; // clears not beaten by a set

   // set wins over clear in the same cycle
   assign flags_nxt = ((flags & ~clr) | rise_w) & IMPL;

   // synchroniser and edge history
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
      end else begin
         sync1_r <= evt_in;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // sticky flags
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flags <= '0;
      end else begin
         flags <= flags_nxt;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   edge_latch_a: assert property (@(posedge mclk) disable iff (!rstn)
      (|rise_w) |=> ((flags & $past(rise_w)) == $past(rise_w)))
      else $error("edge did not latch its flag");
   read_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
      (|clr_only_w) |=> ((flags & $past(clr_only_w)) == '0))
      else $error("cleared flag still set");

endmodule : imb_flag_bank
`default_nettype wire

// ==== hdl/imb_top.sv ====
// interrupt mask bank: group and source masks, sticky status, irq output
// assumes an apb master on mclk; event inputs asynchronous to mclk;
// psm_reset is a one-cycle pulse from the power state machine on mclk
`timescale 1ns/1ps
`default_nettype none
`include "imb_consts.svh"

// Notes on behaviour
// - group mask holds twelve group bits
// - group mask bits reset to one
// - state machine reset restores all mask defaults
// - zero passes a source, one blocks it
// - source mask bits reset to zero
// - first source mask: charger, clock, battery bits
// - second source mask: sinks, limit, converter, thermal
// - undervoltage mask: four linear, six switching
// - overcurrent mask: single bit fifteen
// - pin mask: one bit per pin
// - flags latch on edge, clear on read
module imb_top #(
   parameter int ADDR_W = 8
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [15:0] evt_status_one,
   input wire logic [15:0] evt_status_two,
   input wire logic [15:0] evt_undervolt,
   input wire logic [15:0] evt_overcurr,
   input wire logic [15:0] evt_pin,
   input wire logic ext_cmp_pend,
   input wire logic audio_pend,
   input wire logic wake_pend,
   input wire logic psm_reset,
   output logic irq
);

   // ************************************************************
   // elaboration check
   // ************************************************************
   generate
      if (ADDR_W < 8) begin : g_bad_addr
         $error("imb_top: ADDR_W must be at least eight");
      end
   endgenerate

   // ************************************************************
   // tables of mask and status slots
   // ************************************************************
   localparam int NMASK = 6; // group mask plus five source masks
   localparam int NSTAT = 5; // five status words
   localparam int WW = `IMB_WORD_W;

   // reset value per mask slot
   localparam imb_pkg::imb_word_t MASK_RST [NMASK] = '{
      `IMB_GRP_RST, `IMB_SRC_RST, `IMB_SRC_RST,
      `IMB_SRC_RST, `IMB_SRC_RST, `IMB_SRC_RST};
   // implemented bits per mask slot
   localparam imb_pkg::imb_word_t MASK_IMPL [NMASK] = '{
      `IMB_IMPL_GRP, `IMB_IMPL_ONE, `IMB_IMPL_TWO,
      `IMB_IMPL_UV, `IMB_IMPL_OC, `IMB_IMPL_GP};
   // slot code per mask register
   localparam imb_pkg::imb_reg_e MASK_SLOT [NMASK] = '{
      imb_pkg::IMB_GRP, imb_pkg::IMB_M1, imb_pkg::IMB_M2,
      imb_pkg::IMB_MUV, imb_pkg::IMB_MOC, imb_pkg::IMB_MGP};
   // slot code per status register
   localparam imb_pkg::imb_reg_e STAT_SLOT [NSTAT] = '{
      imb_pkg::IMB_S1, imb_pkg::IMB_S2, imb_pkg::IMB_SUV,
      imb_pkg::IMB_SOC, imb_pkg::IMB_SGP};
   // status bits that exist, packed low word first
   localparam logic [`IMB_FLAG_W-1:0] FLAG_IMPL = {
      `IMB_IMPL_GP, `IMB_IMPL_OC, `IMB_IMPL_UV,
      `IMB_IMPL_TWO, `IMB_IMPL_ONE};

   // ************************************************************
   // address decoding
   // ************************************************************
   // index to slot; misaligned or unknown gives none
   function automatic imb_pkg::imb_reg_e slot_of(
      input logic [5:0] idx,
      input logic [1:0] lsb
   );
      imb_pkg::imb_reg_e s;
      s = imb_pkg::IMB_NONE;
      if (lsb != `IMB_ALIGN_OK) begin
         s = imb_pkg::IMB_NONE;
      end else if (idx == `IMB_IDX_GRP) begin
         s = imb_pkg::IMB_GRP;
      end else if (idx == `IMB_IDX_M1) begin
         s = imb_pkg::IMB_M1;
      end else if (idx == `IMB_IDX_M2) begin
         s = imb_pkg::IMB_M2;
      end else if (idx == `IMB_IDX_UV) begin
         s = imb_pkg::IMB_MUV;
      end else if (idx == `IMB_IDX_OC) begin
         s = imb_pkg::IMB_MOC;
      end else if (idx == `IMB_IDX_GP) begin
         s = imb_pkg::IMB_MGP;
      end else if (idx == `IMB_IDX_S1) begin
         s = imb_pkg::IMB_S1;
      end else if (idx == `IMB_IDX_S2) begin
         s = imb_pkg::IMB_S2;
      end else if (idx == `IMB_IDX_SUV) begin
         s = imb_pkg::IMB_SUV;
      end else if (idx == `IMB_IDX_SOC) begin
         s = imb_pkg::IMB_SOC;
      end else if (idx == `IMB_IDX_SGP) begin
         s = imb_pkg::IMB_SGP;
      end
      return s;
   endfunction : slot_of

   // byte-lane merge of a write into a mask word
   function automatic imb_pkg::imb_word_t merge(
      input imb_pkg::imb_word_t old,
      input logic [15:0] wd,
      input logic [1:0] strb,
      input imb_pkg::imb_word_t impl
   );
      imb_pkg::imb_word_t v;
      v = old;
      if (strb[0]) begin
         v[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         v[15:8] = wd[15:8];
      end
      return v & impl;
   endfunction : merge

   // decoded slot of the current bus address
   wire imb_pkg::imb_reg_e slot_w = slot_of(paddr[7:2], paddr[1:0]);
   wire unmapped_w = (slot_w == imb_pkg::IMB_NONE);
   wire setup_w = psel & ~penable; // setup phase
   wire acc_w = psel & penable; // access phase, always ready
   wire wr_acc_w = acc_w & pwrite; // write takes effect
   wire rd_acc_w = acc_w & ~pwrite; // read completes

   // no wait states; error only on unmapped access
   assign pready = 1'b1;
   assign pslverr = acc_w & unmapped_w;

   // ************************************************************
   // mask registers
   // ************************************************************
   imb_pkg::imb_word_t mask_r [NMASK]; // 0 group, 1..5 source masks
   imb_pkg::imb_word_t mask_nxt [NMASK];
   imb_pkg::imb_word_t rd_acc_or [NMASK+NSTAT+1]; // read mux chain
   logic [`IMB_FLAG_W-1:0] flags_w; // sticky flags from the bank
   logic [`IMB_FLAG_W-1:0] clr_w; // flags to clear on this read

   assign rd_acc_or[0] = '0;

   genvar k;
   generate
      for (k = 0; k < NMASK; k++) begin : g_mask
         wire sel_w = (slot_w == MASK_SLOT[k]);
         // state machine reset beats a write in the same cycle
         assign mask_nxt[k] = psm_reset ? MASK_RST[k] :
            (wr_acc_w & sel_w) ?
            merge(mask_r[k], pwdata[15:0], pstrb[1:0], MASK_IMPL[k]) :
            mask_r[k];
         // read term for this mask
         assign rd_acc_or[k+1] = rd_acc_or[k] |
            (sel_w ? mask_r[k] : '0);

         // mask flip-flops, defaults on reset
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               mask_r[k] <= MASK_RST[k];
            end else begin
               mask_r[k] <= mask_nxt[k];
            end
         end
      end

      for (k = 0; k < NSTAT; k++) begin : g_stat
         wire sel_w = (slot_w == STAT_SLOT[k]);
         // read term for this status word
         assign rd_acc_or[NMASK+k+1] = rd_acc_or[NMASK+k] |
            (sel_w ? flags_w[WW*k +: WW] : '0);
         // clear exactly the bits that were returned
         assign clr_w[WW*k +: WW] = (rd_acc_w & sel_w) ?
            prdata[WW-1:0] : '0;
      end
   endgenerate

   // word returned for the decoded slot; reserved bits read zero
   wire imb_pkg::imb_word_t rd_word_w = rd_acc_or[NMASK+NSTAT];

   // read data captured in the setup phase, held through access
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prdata <= '0;
      end else if (setup_w) begin
         prdata <= {{(32-WW){1'b0}}, rd_word_w};
      end
   end

   // ************************************************************
   // sticky status flags
   // ************************************************************
   imb_flag_bank #(
      .W(`IMB_FLAG_W),
      .IMPL(FLAG_IMPL)
   ) u_flags (
      .mclk(mclk),
      .rstn(rstn),
      .evt_in({evt_pin, evt_overcurr, evt_undervolt, evt_status_two,
               evt_status_one}),
      .clr(clr_w),
      .flags(flags_w)
   );

   // ************************************************************
   // outside group pendings, synchronised
   // ************************************************************
   logic [2:0] ext_s1_r; // first stage, read by ext_s2_r only
   logic [2:0] ext_s2_r; // {wake, audio, ext comparator}

   // two-flop synchroniser
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ext_s1_r <= '0;
         ext_s2_r <= '0;
      end else begin
         ext_s1_r <= {wake_pend, audio_pend, ext_cmp_pend};
         ext_s2_r <= ext_s1_r;
      end
   end

   // ************************************************************
   // masking and interrupt summary
   // ************************************************************
   // a mask bit of one blocks its flag; latching is not affected
   wire imb_pkg::imb_word_t live1_w = flags_w[0 +: WW] & ~mask_r[1];
   wire imb_pkg::imb_word_t live2_w = flags_w[WW +: WW] & ~mask_r[2];
   wire imb_pkg::imb_word_t liveuv_w = flags_w[2*WW +: WW] & ~mask_r[3];
   wire imb_pkg::imb_word_t liveoc_w = flags_w[3*WW +: WW] & ~mask_r[4];
   wire imb_pkg::imb_word_t livegp_w = flags_w[4*WW +: WW] & ~mask_r[5];

   // pending per group, before the group mask
   imb_pkg::imb_word_t grp_pend_w;
   always_comb begin
      grp_pend_w = '0;
      grp_pend_w[`IMB_G_CHG] = |(live1_w & `IMB_F_CHG);
      grp_pend_w[`IMB_G_RTC] = |(live1_w & `IMB_F_RTC);
      grp_pend_w[`IMB_G_CS] = |(live2_w & `IMB_F_CS);
      grp_pend_w[`IMB_G_USB] = |(live2_w & `IMB_F_USB);
      grp_pend_w[`IMB_G_AUX] = |(live2_w & `IMB_F_AUX);
      grp_pend_w[`IMB_G_SYS] = |(live2_w & `IMB_F_SYS);
      grp_pend_w[`IMB_G_UV] = |liveuv_w;
      grp_pend_w[`IMB_G_OC] = |liveoc_w;
      grp_pend_w[`IMB_G_GP] = |livegp_w;
      grp_pend_w[`IMB_G_EXT] = ext_s2_r[0];
      grp_pend_w[`IMB_G_AUD] = ext_s2_r[1];
      grp_pend_w[`IMB_G_WAKE] = ext_s2_r[2];
   end

   // both the source and its group must be unmasked
   wire irq_nxt = |(grp_pend_w & ~mask_r[0] & `IMB_IMPL_GRP);

   // registered level interrupt
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_nxt;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   wire wr_full_w = wr_acc_w & (pstrb[1:0] == 2'b11) & ~psm_reset;
   // some group pending while the group mask is not fully closed
   wire any_open_w = (|grp_pend_w) & (mask_r[0] != `IMB_IMPL_GRP);

   grp_default_a: assert property (psm_reset |=>
      (mask_r[0] == `IMB_GRP_RST))
      else $error("group mask not at default after psm reset");
   src_default_a: assert property (psm_reset |=>
      (mask_r[1] == '0 && mask_r[2] == '0 && mask_r[3] == '0 &&
       mask_r[4] == '0 && mask_r[5] == '0))
      else $error("source masks not cleared after psm reset");
   src_reset_val_a: assert property ($rose(rstn) |->
      (mask_r[3] == `IMB_SRC_RST && mask_r[5] == `IMB_SRC_RST))
      else $error("source mask wrong after reset");
   grp_write_a: assert property ((wr_full_w &&
      slot_w == imb_pkg::IMB_GRP) |=>
      (mask_r[0] == ($past(pwdata[15:0]) & `IMB_IMPL_GRP)))
      else $error("group mask write lost");
   one_write_a: assert property ((wr_full_w &&
      slot_w == imb_pkg::IMB_M1) |=>
      (mask_r[1] == ($past(pwdata[15:0]) & `IMB_IMPL_ONE)))
      else $error("first source mask write lost");
   two_write_a: assert property ((wr_full_w &&
      slot_w == imb_pkg::IMB_M2) |=>
      (mask_r[2] == ($past(pwdata[15:0]) & `IMB_IMPL_TWO)))
      else $error("second source mask write lost");
   uv_write_a: assert property ((wr_full_w &&
      slot_w == imb_pkg::IMB_MUV) |=> (mask_r[3][7:6] == 2'b00 &&
      mask_r[3][11:8] == $past(pwdata[11:8])))
      else $error("undervoltage mask write wrong");
   oc_write_a: assert property ((wr_full_w &&
      slot_w == imb_pkg::IMB_MOC) |=>
      (mask_r[4] == {$past(pwdata[15]), 15'h0000}))
      else $error("overcurrent mask write wrong");
   pin_write_a: assert property ((wr_full_w &&
      slot_w == imb_pkg::IMB_MGP) |=>
      (mask_r[5] == ($past(pwdata[15:0]) & `IMB_IMPL_GP)))
      else $error("pin mask write wrong");
   all_masked_a: assert property ((mask_r[0] == `IMB_IMPL_GRP) [*2]
      |-> !irq)
      else $error("irq with every group masked");
   irq_cause_a: assert property (irq |->
      $past(any_open_w))
      else $error("irq without an unmasked pending source");
   masked_latch_a: assert property ((mask_r[1][15] &&
      flags_w[15] && !clr_w[15]) |=> flags_w[15])
      else $error("masked flag dropped without a read");

   irq_seen_c: cover property ($rose(irq));
   read_clear_c: cover property (rd_acc_w && (|clr_w));
   psm_write_c: cover property (psm_reset && wr_acc_w);
   unmapped_c: cover property (pslverr);

endmodule : imb_top
`default_nettype wire

// ==== verification/imb_host_model.sv ====
// host side model: apb master issuing one transfer per call
// assumes an apb slave on mclk; no transfer before reset release
`timescale 1ns/1ps
`default_nettype none

module imb_host_model (
   input wire logic mclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   // ************************************************************
   // bus idle at time zero
   // ************************************************************
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
   end

   // setup, access held until pready, take answer at that edge
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [15:0] wd, input logic [3:0] st,
                       output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, wd};
      pstrb <= st;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // no cycle count assumed: the bench watchdog ends a hang
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : imb_host_model

`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench of the interrupt mask bank
// assumes imb_top and imb_host_model compiled; header on include path
`timescale 1ns/1ps
`default_nettype none
`include "imb_consts.svh"

module testbench;
   logic mclk, rstn, psm_reset, irq, psel, penable, pwrite;
   logic pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [79:0] evt_all; // five event words side by side
   logic [2:0] pends; // ext, audio, wake levels
   int err_count, checks;
   // mask addresses and their implemented bits
   logic [7:0] ma[6] = '{8'h80, 8'h84, 8'h88, 8'h90, 8'h94, 8'h98};
   // status addresses, one per event word
   logic [7:0] sa[5] = '{8'h64, 8'h68, 8'h70, 8'h74, 8'h78};
   logic [15:0] im[6] = '{16'h33ff, 16'hfee7, 16'h35ff, 16'h0f3f,
                          16'h8000, 16'h1fff};
   logic [15:0] shadow[6];
   // event vectors: word, bit, group
   int vs[9] = '{0, 0, 1, 1, 1, 1, 2, 3, 4};
   int vb[9] = '{15, 6, 13, 10, 5, 2, 9, 15, 12};
   int vg[9] = '{2, 4, 9, 1, 5, 3, 12, 13, 6};
   int pg[3] = '{8, 7, 0};

   imb_top dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .evt_status_one(evt_all[15:0]), .evt_status_two(evt_all[31:16]),
      .evt_undervolt(evt_all[47:32]), .evt_overcurr(evt_all[63:48]),
      .evt_pin(evt_all[79:64]), .ext_cmp_pend(pends[0]),
      .audio_pend(pends[1]), .wake_pend(pends[2]),
      .psm_reset(psm_reset), .irq(irq));
   imb_host_model host (.mclk(mclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr));

   // ************************************************************
   // helpers
   // ************************************************************
   // byte-lane merge of a write into a mask word
   function automatic logic [15:0] merge(input logic [15:0] o, w, m,
                                         input logic [3:0] s);
      logic [15:0] l;
      l = {{8{s[1]}}, {8{s[0]}}};
      return ((o & ~l) | (w & l)) & m;
   endfunction : merge

   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one transfer with expected data and error flag
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [15:0] d, e, input logic [3:0] s,
                      input logic bad);
      logic [31:0] rd;
      logic er;
      host.xfer(w, a, d, s, rd, er);
      if (!w) chk("prdata", {16'h0000, e}, rd);
      chk("pslverr", {31'h0, bad}, {31'h0, er});
   endtask : bus

   // wait bounded for irq level, or check it holds every cycle
   task automatic irq_is(input logic v, input int n, input logic hold);
      int k;
      for (k = 0; k < n; k++) begin
         @(negedge mclk);
         if (hold) chk("irq", {31'h0, v}, {31'h0, irq});
         else if (irq === v) break;
      end
      if (!hold) chk("irq", {31'h0, v}, {31'h0, irq});
   endtask : irq_is

   task automatic set_bit(input int i, input logic v);
      @(posedge mclk);
      evt_all[i] <= v;
   endtask : set_bit

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   // ************************************************************
   // clock, reset, watchdog
   // ************************************************************
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   initial begin
      #200000;
      err_count++;
      wrap_up();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      int i, r, s, b, g, v;
      logic [15:0] w, gm;
      logic [3:0] st;
      rstn = 1'b0;
      psm_reset = 1'b0;
      evt_all = '0;
      pends = 3'b000;
      err_count = 0;
      checks = 0;
      void'($urandom(96222));
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      // reset values, status empty, then full writes
      for (r = 0; r < 6; r++) begin
         shadow[r] = (r == 0) ? 16'h33ff : 16'h0000;
         bus(1'b0, ma[r], 0, shadow[r], 4'hf, 1'b0);
         if (r < 5) bus(1'b0, sa[r], 0, 16'h0000, 4'hf, 1'b0);
         bus(1'b1, ma[r], 16'hffff, 0, 4'hf, 1'b0);
         shadow[r] = im[r];
         bus(1'b0, ma[r], 0, im[r], 4'hf, 1'b0);
      end
      $display("test reset and layout done");
      // random writes with byte strobes; unmapped place refused
      for (i = 0; i < 24; i++) begin
         r = $urandom % 6;
         w = 16'($urandom);
         st = 4'($urandom);
         bus(1'b1, ma[r], w, 0, st, 1'b0);
         shadow[r] = merge(shadow[r], w, im[r], st);
         bus(1'b0, ma[r], 0, shadow[r], 4'hf, 1'b0);
      end
      bus(1'b1, 8'h7c, 16'hffff, 0, 4'hf, 1'b1);
      bus(1'b0, 8'h7c, 0, 16'h0000, 4'hf, 1'b1);
      bus(1'b1, 8'h64, 16'hffff, 0, 4'hf, 1'b0);
      bus(1'b0, 8'h64, 0, 16'h0000, 4'hf, 1'b0);
      $display("test random writes done");
      // state machine reset restores defaults
      @(posedge mclk);
      psm_reset <= 1'b1;
      @(posedge mclk);
      psm_reset <= 1'b0;
      for (r = 0; r < 6; r++)
         bus(1'b0, ma[r], 0, (r == 0) ? 16'h33ff : 16'h0, 4'hf, 1'b0);
      // state machine reset in the access cycle of a write wins
      fork
         bus(1'b1, 8'h80, 16'h0000, 0, 4'hf, 1'b0);
         begin
            repeat (2) @(posedge mclk);
            psm_reset <= 1'b1;
            @(posedge mclk);
            psm_reset <= 1'b0;
         end
      join
      bus(1'b0, 8'h80, 0, 16'h33ff, 4'hf, 1'b0);
      $display("test state reset done");
      // each event group: pass, source masked, group masked
      for (i = 0; i < 13; i++) begin
         v = (i < 9) ? i : $urandom % 9;
         s = vs[v];
         b = vb[v];
         g = vg[v];
         gm = 16'h33ff & ~(16'h0001 << g);
         bus(1'b1, 8'h80, gm, 0, 4'hf, 1'b0);
         bus(1'b1, ma[s + 1], ~(16'h0001 << b), 0, 4'hf, 1'b0);
         set_bit(s * 16 + b, 1'b1);
         irq_is(1'b1, 8, 1'b0);
         bus(1'b0, sa[s], 0, 16'h0001 << b, 4'hf, 1'b0);
         irq_is(1'b0, 4, 1'b0);
         bus(1'b0, sa[s], 0, 16'h0000, 4'hf, 1'b0);
         set_bit(s * 16 + b, 1'b0);
         bus(1'b1, ma[s + 1], 16'hffff, 0, 4'hf, 1'b0);
         set_bit(s * 16 + b, 1'b1);
         irq_is(1'b0, 6, 1'b1);
         bus(1'b0, sa[s], 0, 16'h0001 << b, 4'hf, 1'b0);
         set_bit(s * 16 + b, 1'b0);
         bus(1'b1, ma[s + 1], 16'h0000, 0, 4'hf, 1'b0);
         bus(1'b1, 8'h80, 16'h33ff, 0, 4'hf, 1'b0);
         set_bit(s * 16 + b, 1'b1);
         irq_is(1'b0, 6, 1'b1);
         bus(1'b1, 8'h80, gm, 0, 4'hf, 1'b0);
         irq_is(1'b1, 4, 1'b0);
         bus(1'b0, sa[s], 0, 16'h0001 << b, 4'hf, 1'b0);
         irq_is(1'b0, 4, 1'b0);
         set_bit(s * 16 + b, 1'b0);
         bus(1'b1, 8'h80, 16'h33ff, 0, 4'hf, 1'b0);
      end
      $display("test event groups done");
      // outside groups arrive as levels
      for (i = 0; i < 3; i++) begin
         bus(1'b1, 8'h80, 16'h33ff & ~(16'h0001 << pg[i]), 0, 4'hf, 1'b0);
         @(posedge mclk);
         pends[i] <= 1'b1;
         irq_is(1'b1, 8, 1'b0);
         bus(1'b1, 8'h80, 16'h33ff, 0, 4'hf, 1'b0);
         irq_is(1'b0, 4, 1'b0);
         @(posedge mclk);
         pends[i] <= 1'b0;
      end
      $display("test level groups done");
      wrap_up();
   end
endmodule : testbench

`default_nettype wire
